// ==== msq_axil_regs.sv ====
// Purpose: AXI4-Lite slave for control and status of the queue block
// Assumes: One write and one read outstanding at most
// Notes: Unmapped addresses answer SLVERR, read zero
`timescale 1ns/1ns
`include "msq_cfg.svh"
module msq_axil_regs
   import msq_pkg::*;
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic [7:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   input wire logic [7:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready,
   input wire logic [15:0] qptr,
   input wire logic [15:0] last_tag,
   input wire logic [15:0] entries,
   output logic [3:0] ctrl,
   output logic [15:0] qbase,
   output logic qbase_load,
   output logic [15:0] mode_tbl
);
   typedef struct packed {
      logic aw_got;
      logic w_got;
      logic [7:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [3:0] ctrl;
      logic [15:0] qbase;
      logic qload;
      logic [15:0] mtbl;
      logic aw_rdy;
      logic w_rdy;
      logic ar_rdy;
   } msq_reg_st_t;
   msq_reg_st_t s_q, s_d;
   logic aw_hs, w_hs;

   assign aw_hs = s_awvalid && s_q.aw_rdy;
   assign w_hs = s_wvalid && s_q.w_rdy;

   always_comb begin
      s_d = s_q;
      s_d.qload = 1'b0;
      if (aw_hs) begin
         s_d.aw_got = 1'b1;
         s_d.awaddr = s_awaddr;
      end
      if (w_hs) begin
         s_d.w_got = 1'b1;
         s_d.wdata = s_wdata;
         s_d.wstrb = s_wstrb;
      end
      if (s_q.aw_got && s_q.w_got) begin
         s_d.aw_got = 1'b0;
         s_d.w_got = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = `MSQ_RESP_OKAY;
         case (s_q.awaddr)
            `MSQ_OFF_CTRL: if (s_q.wstrb[0]) s_d.ctrl = s_q.wdata[3:0];
            `MSQ_OFF_QBASE: begin
               if (s_q.wstrb[0]) s_d.qbase[7:0] = s_q.wdata[7:0];
               if (s_q.wstrb[1]) s_d.qbase[15:8] = s_q.wdata[15:8];
               s_d.qload = 1'b1;
            end
            `MSQ_OFF_MODETBL: begin
               if (s_q.wstrb[0]) s_d.mtbl[7:0] = s_q.wdata[7:0];
               if (s_q.wstrb[1]) s_d.mtbl[15:8] = s_q.wdata[15:8];
            end
            `MSQ_OFF_QPTR, `MSQ_OFF_TAG, `MSQ_OFF_STAT: ;
            default: s_d.bresp = `MSQ_RESP_SLVERR;
         endcase
      end
      if (s_q.bvalid && s_bready) s_d.bvalid = 1'b0;
      if (s_q.rvalid && s_rready) s_d.rvalid = 1'b0;
      if (s_arvalid && s_q.ar_rdy) begin
         s_d.rvalid = 1'b1;
         s_d.rresp = `MSQ_RESP_OKAY;
         case (s_araddr)
            `MSQ_OFF_CTRL: s_d.rdata = {28'h0000000, s_q.ctrl};
            `MSQ_OFF_QBASE: s_d.rdata = {16'h0000, s_q.qbase};
            `MSQ_OFF_QPTR: s_d.rdata = {16'h0000, qptr};
            `MSQ_OFF_TAG: s_d.rdata = {16'h0000, last_tag};
            `MSQ_OFF_STAT: s_d.rdata = {16'h0000, entries};
            `MSQ_OFF_MODETBL: s_d.rdata = {16'h0000, s_q.mtbl};
            default: begin
               s_d.rdata = 32'h00000000;
               s_d.rresp = `MSQ_RESP_SLVERR;
            end
         endcase
      end
      s_d.aw_rdy = !s_d.aw_got && !s_d.bvalid;
      s_d.w_rdy = !s_d.w_got && !s_d.bvalid;
      s_d.ar_rdy = !s_d.rvalid;
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         s_q <= '0;
         s_q.qbase <= `MSQ_QBASE_RST;
         s_q.mtbl <= `MSQ_MODETBL_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign s_awready = s_q.aw_rdy;
   assign s_wready = s_q.w_rdy;
   assign s_bvalid = s_q.bvalid;
   assign s_bresp = s_q.bresp;
   assign s_arready = s_q.ar_rdy;
   assign s_rvalid = s_q.rvalid;
   assign s_rdata = s_q.rdata;
   assign s_rresp = s_q.rresp;
   assign ctrl = s_q.ctrl;
   assign qbase = s_q.qbase;
   assign qbase_load = s_q.qload;
   assign mode_tbl = s_q.mtbl;
endmodule

// ==== msq_cfg.svh ====
// Purpose: Constants for the monitor status queue block
// Assumes: 100 MHz core clock
// Notes: Offsets are byte addresses on the register bus
`ifndef MSQ_CFG_SVH
`define MSQ_CFG_SVH
`define MSQ_CLK_PERIOD_NS 10
`define MSQ_GAP_STEP_NS 500
`define MSQ_GAP_STEP_CYC (`MSQ_GAP_STEP_NS / `MSQ_CLK_PERIOD_NS)
`define MSQ_GAP_MAX 8'hff
`define MSQ_MODE_TBL_FIRST 16'h0108
`define MSQ_MODE_TBL_LAST 16'h010f
`define MSQ_OFF_CTRL 8'h00
`define MSQ_OFF_QBASE 8'h04
`define MSQ_OFF_QPTR 8'h08
`define MSQ_OFF_TAG 8'h0c
`define MSQ_OFF_STAT 8'h10
`define MSQ_OFF_MODETBL 8'h14
`define MSQ_CTRL_MODE_LSB 0
`define MSQ_CTRL_SUPPRESS 2
`define MSQ_CTRL_ENH_MEM 3
`define MSQ_QBASE_RST 16'h0000
`define MSQ_MODETBL_RST 16'h0000
`define MSQ_RESP_OKAY 2'b00
`define MSQ_RESP_SLVERR 2'b10
`endif

// ==== msq_gap_timer.sv ====
// Purpose: Counts idle gap between bus words in half-microsecond steps
// Assumes: word_end and word_start are one-cycle pulses on core_clk
// Notes: Saturates rather than wrapping
`timescale 1ns/1ns
`include "msq_cfg.svh"
module msq_gap_timer
   import msq_pkg::*;
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic word_end,
   input wire logic word_start,
   output logic [7:0] gap_time
);
   typedef struct packed {
      logic [7:0] pre;
      logic [7:0] gap;
      logic run;
   } msq_gap_st_t;
   msq_gap_st_t s_q, s_d;

   always_comb begin
      s_d = s_q;
      if (word_end) begin
         s_d.run = 1'b1;
         s_d.gap = 8'h00;
         s_d.pre = 8'h00;
      end else if (word_start) begin
         s_d.run = 1'b0;
      end else if (s_q.run) begin
         if (s_q.pre == 8'(`MSQ_GAP_STEP_CYC - 1)) begin
            s_d.pre = 8'h00;
            // Holds at 127.5 us instead of wrapping to a short gap
            if (s_q.gap != `MSQ_GAP_MAX) s_d.gap = s_q.gap + 8'h01;
         end else begin
            s_d.pre = s_q.pre + 8'h01;
         end
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) s_q <= '0;
      else s_q <= s_d;
   end

   assign gap_time = s_q.gap;
endmodule

// ==== msq_pkg.sv ====
// Purpose: Types for the monitor status queue block
// Assumes: Constants live in msq_cfg.svh
// Notes: Mode enumeration shared by the bus slave and the core
package msq_pkg;
   typedef enum logic [1:0] {
      MSQ_MODE_WORD_MON,
      MSQ_MODE_ENH_RT,
      MSQ_MODE_ENH_MON,
      MSQ_MODE_RT_MON
   } msq_mode_t;
endpackage

// ==== msq_ram_model.sv ====
// Purpose: Shared RAM seen by the host, captures queue writes
// Assumes: ram_we is a one-cycle pulse
// Notes: Slow mode holds ram_busy three cycles of four
`timescale 1ns/1ns
module msq_ram_model (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic slow,
   input wire logic ram_we,
   input wire logic [15:0] ram_addr,
   input wire logic [15:0] ram_wdata,
   output logic ram_busy
);
   logic [15:0] mem [0:1023];
   int wr_cnt;
   logic [1:0] div_q;
   ////////////////////////////////////////////////////////////////////////////
   // Only 1K words kept; queue base must sit below that
   assign ram_busy = slow && (div_q != 2'h0);
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         wr_cnt <= 0;
         div_q <= 2'h0;
      end else begin
         div_q <= div_q + 2'h1;
         if (ram_we) begin
            mem[ram_addr[9:0]] <= ram_wdata;
            wr_cnt <= wr_cnt + 1;
         end
      end
   end
endmodule

// ==== msq_top.sv ====
// Purpose: Word monitor tag builder and interrupt status queue writer
// Assumes: Decoder pulses are synchronous to core_clk, one cycle each
// Notes: RAM writes are a simple write port with a stall input
//
// What this block does
// - Tag bits 15..8 hold gap time in 0.5 us steps, saturating 127.5 us.
// - Tag bit 7 is always one.
// - Tag bit 6 is zero only for a valid command to this terminal.
// - Tag bit 5 is zero only for a valid broadcast command, address 31.
// - Tag bit 4 is one when the word had any reception error.
// - Tag bit 3 is one for command sync, zero for data sync.
// - Tag bit 2 is zero for bus A, one for bus B.
// - Tag bit 1 is one when words are contiguous, else gap recorded.
// - Tag bit 0 is zero only for a valid mode code command.
// - Enhanced RT, monitor or combined modes queue two words per event.
// - Event word bit 0 is one for message events, zero otherwise.
// - Message events carry a block status pointer as parameter.
// - Bit 15 flags transmitter watchdog expiry, with RT pointer, or monitor pointer in monitor-only mode.
// - Bit 14: illegal command in RT, valid message in monitor unless suppressed.
// - Bits 13,12 monitor data stack; bits 11,10 RT circular buffer.
// - Bits 9,8 monitor command stack; bits 7,6 RT command stack.
// - Bit 5 flags external RAM handshake failure in transparent mode.
// - Bit 4 flags protocol error, loopback mismatch or response timeout.
// - Bit 3 flags mode command only if enabled in its lookup table.
// - Bit 2 flags subaddress end-of-message under enhanced memory with enable.
// - Bit 1 flags any completed message.
// - Non-message bits 4,3,2 use zero parameter; bit 1 uses failing address.
// - Non-message word bits 15..5 are written zero.
//
// The AXI4-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`include "msq_cfg.svh"
module msq_top
   import msq_pkg::*;
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic [7:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   input wire logic [7:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready,
   input wire logic word_start,
   input wire logic word_end,
   input wire logic word_done,
   input wire logic word_own_cmd,
   input wire logic word_broadcast_cmd_n_cmd,
   input wire logic word_mode_cmd,
   input wire logic word_err,
   input wire logic word_cmd_sync,
   input wire logic bus_select,
   input wire logic contiguous_flag,
   input wire logic ev_watchdog,
   input wire logic ev_illegal_cmd,
   input wire logic ev_valid_msg,
   input wire logic ev_mdata_half,
   input wire logic ev_mdata_roll,
   input wire logic ev_rtbuf_half,
   input wire logic ev_rtbuf_roll,
   input wire logic ev_mcmd_half,
   input wire logic ev_mcmd_roll,
   input wire logic ev_own_terminal_cmd_n_half,
   input wire logic ev_own_terminal_cmd_n_roll,
   input wire logic ev_handshake_fail,
   input wire logic ev_msg_error,
   input wire logic ev_mode_cmd,
   input wire logic [2:0] mode_cmd_idx,
   input wire logic ev_sa_done,
   input wire logic transmit_done_irq_en,
   input wire logic receive_done_irq_en,
   input wire logic broadcast_done_irq_en,
   input wire logic message_end,
   input wire logic [15:0] rt_bsw_ptr,
   input wire logic [15:0] mt_bsw_ptr,
   input wire logic ev_ttag_roll,
   input wire logic ev_addr_parity,
   input wire logic ev_selftest_done,
   input wire logic ev_ram_parity,
   input wire logic [15:0] ram_parity_addr,
   input wire logic ram_busy,
   output logic ram_we,
   output logic [15:0] ram_addr,
   output logic [15:0] ram_wdata,
   output logic ev_overrun
);
   typedef enum logic [1:0] {
      MSQ_IDLE,
      MSQ_WR_EVENT,
      MSQ_WR_PARAM
   } msq_state_t;

   typedef struct packed {
      msq_state_t st;
      logic [15:0] ev_word;
      logic [15:0] param;
      logic msg_pend;
      logic [15:0] msg_word;
      logic [15:0] msg_param;
      logic nm_pend;
      logic [15:0] nm_word;
      logic [15:0] nm_param;
      logic [15:0] qptr;
      logic [15:0] entries;
      logic [15:0] tag;
      logic we;
      logic [15:0] addr;
      logic [15:0] wdata;
      logic overrun;
   } msq_top_st_t;

   msq_top_st_t s_q, s_d;
   logic [3:0] ctrl;
   logic [15:0] qbase;
   logic qbase_load;
   logic [15:0] mode_tbl;
   logic [7:0] gap_time;
   msq_mode_t mode;
   logic enh_mode;
   logic mon_side;
   logic rt_side;
   logic [15:0] msg_bits;
   logic [15:0] nm_bits;
   logic [15:0] msg_ptr;
   logic [4:0] nm_raw;
   logic [4:0] nm_sync1;
   logic [4:0] nm_sync2;

   //////////////////////////////////////////////////////////////////////
   msq_axil_regs u_regs (
      .core_clk(core_clk),
      .resetn(resetn),
      .s_awaddr(s_awaddr),
      .s_awvalid(s_awvalid),
      .s_awready(s_awready),
      .s_wdata(s_wdata),
      .s_wstrb(s_wstrb),
      .s_wvalid(s_wvalid),
      .s_wready(s_wready),
      .s_bresp(s_bresp),
      .s_bvalid(s_bvalid),
      .s_bready(s_bready),
      .s_araddr(s_araddr),
      .s_arvalid(s_arvalid),
      .s_arready(s_arready),
      .s_rdata(s_rdata),
      .s_rresp(s_rresp),
      .s_rvalid(s_rvalid),
      .s_rready(s_rready),
      .qptr(s_q.qptr),
      .last_tag(s_q.tag),
      .entries(s_q.entries),
      .ctrl(ctrl),
      .qbase(qbase),
      .qbase_load(qbase_load),
      .mode_tbl(mode_tbl)
   );

   msq_gap_timer u_gap (
      .core_clk(core_clk),
      .resetn(resetn),
      .word_end(word_end),
      .word_start(word_start),
      .gap_time(gap_time)
   );

   //////////////////////////////////////////////////////////////////////
   // Event decode
   assign mode = msq_mode_t'(ctrl[`MSQ_CTRL_MODE_LSB +: 2]);
   assign enh_mode = (mode != MSQ_MODE_WORD_MON);
   assign mon_side = (mode == MSQ_MODE_ENH_MON) || (mode == MSQ_MODE_RT_MON);
   assign rt_side = (mode == MSQ_MODE_ENH_RT) || (mode == MSQ_MODE_RT_MON);

   // RT pointer wins in combined mode; monitor-only mode uses monitor pointer
   assign msg_ptr = rt_side ? rt_bsw_ptr : mt_bsw_ptr;

   // Self-test and parity pulses may come from slower logic, so resample
   assign nm_raw = {ev_ttag_roll, ev_addr_parity, ev_selftest_done, ev_ram_parity, 1'b0};

   always_comb begin
      msg_bits = 16'h0000;
      msg_bits[15] = ev_watchdog;
      msg_bits[14] = (rt_side && ev_illegal_cmd) ||
                     (mon_side && ev_valid_msg && !ctrl[`MSQ_CTRL_SUPPRESS]);
      msg_bits[13] = ev_mdata_half;
      msg_bits[12] = ev_mdata_roll;
      msg_bits[11] = ev_rtbuf_half;
      msg_bits[10] = ev_rtbuf_roll;
      msg_bits[9] = ev_mcmd_half;
      msg_bits[8] = ev_mcmd_roll;
      msg_bits[7] = ev_own_terminal_cmd_n_half;
      msg_bits[6] = ev_own_terminal_cmd_n_roll;
      msg_bits[5] = ev_handshake_fail;
      msg_bits[4] = ev_msg_error;
      msg_bits[3] = ev_mode_cmd && mode_tbl[{mode_cmd_idx, 1'b0}];
      msg_bits[2] = ev_sa_done && ctrl[`MSQ_CTRL_ENH_MEM] &&
                    (transmit_done_irq_en || receive_done_irq_en ||
                     broadcast_done_irq_en);
      msg_bits[1] = message_end;
      msg_bits[0] = |msg_bits[15:1];
      nm_bits = {11'h000, nm_sync2};
   end

   //////////////////////////////////////////////////////////////////////
   // Queue writer and tag builder
   always_comb begin
      s_d = s_q;
      s_d.we = 1'b0;
      s_d.overrun = 1'b0;
      if (qbase_load) begin
         s_d.qptr = qbase;
         s_d.entries = 16'h0000;
      end
      if (word_done) begin
         s_d.tag = {contiguous_flag ? 8'h00 : gap_time,
                    1'b1,
                    !word_own_cmd,
                    !word_broadcast_cmd_n_cmd,
                    word_err,
                    word_cmd_sync,
                    bus_select,
                    contiguous_flag,
                    !word_mode_cmd};
      end
      case (s_q.st)
         MSQ_IDLE: begin
            if (s_q.msg_pend) begin
               s_d.ev_word = s_q.msg_word;
               s_d.param = s_q.msg_param;
               s_d.msg_pend = 1'b0;
               s_d.st = MSQ_WR_EVENT;
            end else if (s_q.nm_pend) begin
               s_d.ev_word = s_q.nm_word;
               s_d.param = s_q.nm_param;
               s_d.nm_pend = 1'b0;
               s_d.st = MSQ_WR_EVENT;
            end
         end
         MSQ_WR_EVENT: begin
            if (!ram_busy) begin
               s_d.we = 1'b1;
               s_d.addr = s_q.qptr;
               s_d.wdata = s_q.ev_word;
               s_d.st = MSQ_WR_PARAM;
            end
         end
         MSQ_WR_PARAM: begin
            if (!ram_busy && !s_q.we) begin
               s_d.we = 1'b1;
               s_d.addr = s_q.qptr + 16'h0001;
               s_d.wdata = s_q.param;
               // Pointer moves as the parameter word write is issued, once the event word is in RAM
               s_d.qptr = s_q.qptr + 16'h0002;
               s_d.entries = s_q.entries + 16'h0001;
               s_d.st = MSQ_IDLE;
            end
         end
         default: s_d.st = MSQ_IDLE;
      endcase
      // Merge after the pick, so a word just taken is not queued twice
      if (enh_mode && msg_bits[0]) begin
         if (s_d.msg_pend) s_d.overrun = 1'b1;
         s_d.msg_word = (s_d.msg_pend ? s_d.msg_word : 16'h0000) | msg_bits;
         s_d.msg_pend = 1'b1;
         s_d.msg_param = msg_ptr;
      end
      if (enh_mode && (|nm_bits)) begin
         if (s_d.nm_pend) s_d.overrun = 1'b1;
         s_d.nm_word = (s_d.nm_pend ? s_d.nm_word : 16'h0000) | nm_bits;
         s_d.nm_pend = 1'b1;
         // Only parity fault has an address; others report zero
         s_d.nm_param = nm_bits[1] ? ram_parity_addr : 16'h0000;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         s_q <= '0;
         s_q.st <= MSQ_IDLE;
         s_q.qptr <= `MSQ_QBASE_RST;
         nm_sync1 <= 5'h00;
         nm_sync2 <= 5'h00;
      end else begin
         s_q <= s_d;
         nm_sync1 <= nm_raw;
         nm_sync2 <= nm_sync1;
      end
   end

   assign ram_we = s_q.we;
   assign ram_addr = s_q.addr;
   assign ram_wdata = s_q.wdata;
   assign ev_overrun = s_q.overrun;
endmodule

// ==== msq_top_sva.sv ====
// Purpose: Concurrent checks on the queue writer ports of msq_top
// Assumes: One clock domain, async active-low reset
// Notes: Entry phase is tracked by counting ram_we pulses
`timescale 1ns/1ns
`include "msq_cfg.svh"
module msq_top_sva (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic [7:0] s_awaddr,
   input wire logic s_awvalid,
   input wire logic s_awready,
   input wire logic ev_watchdog,
   input wire logic ev_illegal_cmd,
   input wire logic ev_ram_parity,
   input wire logic [15:0] ram_parity_addr,
   input wire logic ram_we,
   input wire logic [15:0] ram_addr,
   input wire logic [15:0] ram_wdata
);
   logic odd_q;
   logic seen_q;
   logic [15:0] ev_addr_q;
   logic [15:0] ev_word_q;
   logic [15:0] par_q;
   ////////////////////////////////////////////////////////////////////////////
   // Odd write is a parameter word; a base reload restarts the stepping check
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         odd_q <= 1'b0;
         seen_q <= 1'b0;
         ev_addr_q <= 16'h0000;
         ev_word_q <= 16'h0000;
         par_q <= 16'h0000;
      end else begin
         if (ram_we) odd_q <= !odd_q;
         if (ram_we && !odd_q) ev_addr_q <= ram_addr;
         if (ram_we && !odd_q) ev_word_q <= ram_wdata;
         if (ram_we && odd_q) seen_q <= 1'b1;
         if (s_awvalid && s_awready && s_awaddr == `MSQ_OFF_QBASE) seen_q <= 1'b0;
         if (ev_ram_parity) par_q <= ram_parity_addr;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   a_param_addr: assert property (ram_we && odd_q |-> ram_addr == ev_addr_q + 16'h1)
      else $error("parameter word not next to event word");
   a_ptr_step: assert property (ram_we && !odd_q && seen_q |-> ram_addr == ev_addr_q + 16'h2)
      else $error("queue pointer did not advance by two");
   a_we_pulse: assert property (ram_we |=> !ram_we)
      else $error("queue writes back to back");
   a_watchdog_word: assert property (ev_watchdog |-> ##[2:40]
      (ram_we && !odd_q && ram_wdata[15] && ram_wdata[0]))
      else $error("watchdog event word missing");
   a_illegal_word: assert property (ev_illegal_cmd |-> ##[2:40]
      (ram_we && !odd_q && ram_wdata[14] && ram_wdata[0]))
      else $error("illegal command event word missing");
   a_nonmsg_high: assert property (ram_we && !odd_q && !ram_wdata[0] |-> ram_wdata[15:5] == 11'h000)
      else $error("non-message word upper bits set");
   a_nonmsg_zero: assert property (ram_we && odd_q && !ev_word_q[0] && !ev_word_q[1] |->
      ram_wdata == 16'h0000)
      else $error("non-message parameter not zero");
   a_parity_param: assert property (ram_we && odd_q && ev_word_q == 16'h0002 |->
      ram_wdata == par_q)
      else $error("parity parameter not failing address");
   c_msg_entry: cover property (ram_we && !odd_q && ram_wdata[0]);
   c_nonmsg_entry: cover property (ram_we && !odd_q && !ram_wdata[0]);
   c_param_word: cover property (ram_we && odd_q);
endmodule
bind msq_top msq_top_sva msq_top_sva_i (.*);

// ==== testbench.sv ====
// Purpose: Register, tag and queue checks for msq_top
// Assumes: Single 100 MHz clock, bus master changes signals after the edge
// Notes: Expected queue contents read back from the RAM model
`timescale 1ns/1ns
`include "msq_cfg.svh"
module testbench;
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
   logic [31:0] s_wdata = 32'h0;
   logic [3:0] s_wstrb = 4'hf;
   logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
   logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
   logic [1:0] s_bresp, s_rresp;
   logic [31:0] s_rdata;
   logic word_start = 1'b0, word_end = 1'b0, word_done = 1'b0;
   logic word_own_cmd = 1'b0, word_broadcast_cmd_n_cmd = 1'b0, word_mode_cmd = 1'b0, word_err = 1'b0;
   logic word_cmd_sync = 1'b0, bus_select = 1'b0, contiguous_flag = 1'b0;
   logic [15:0] msg_ev = 16'h0;
   logic [3:0] nm_ev = 4'h0;
   logic [2:0] mode_cmd_idx = 3'h0;
   logic transmit_done_irq_en = 1'b0, receive_done_irq_en = 1'b0, broadcast_done_irq_en = 1'b0;
   logic [15:0] rt_bsw_ptr = 16'h0a5a, mt_bsw_ptr = 16'h0b6b, ram_parity_addr = 16'h0123;
   logic ram_busy, ram_we, slow = 1'b0;
   logic [15:0] ram_addr, ram_wdata, qa;
   int error_cnt = 0, comparisons = 0, nw = 0;
   ////////////////////////////////////////////////////////////////////////////
   msq_top msq_top_i (.*, .ev_watchdog(msg_ev[14]), .ev_illegal_cmd(msg_ev[13]),
      .ev_mdata_half(msg_ev[12]), .ev_mdata_roll(msg_ev[11]), .ev_rtbuf_half(msg_ev[10]),
      .ev_rtbuf_roll(msg_ev[9]), .ev_mcmd_half(msg_ev[8]), .ev_mcmd_roll(msg_ev[7]),
      .ev_own_terminal_cmd_n_half(msg_ev[6]), .ev_own_terminal_cmd_n_roll(msg_ev[5]), .ev_handshake_fail(msg_ev[4]),
      .ev_msg_error(msg_ev[3]), .ev_mode_cmd(msg_ev[2]), .ev_sa_done(msg_ev[1]),
      .message_end(msg_ev[0]), .ev_valid_msg(msg_ev[15]), .ev_ttag_roll(nm_ev[3]),
      .ev_addr_parity(nm_ev[2]), .ev_selftest_done(nm_ev[1]), .ev_ram_parity(nm_ev[0]),
      .ev_overrun());
   msq_ram_model msq_ram_model_i (.*);
   initial forever #5 core_clk = ~core_clk;
   initial begin
      #1000000;
      error_cnt++;
      report_and_stop();
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop;
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic give_up;
      $display("[FAIL] wait expected done seen timeout");
      error_cnt++;
      report_and_stop();
   endtask
   // Read: d is the expected data; one bounded wait for the whole transfer
   task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er);
      logic ta, tw, tr, tb, rr, done;
      logic [1:0] rsp;
      logic [31:0] dat;
      int n;
      if (wr) begin
         s_awaddr <= a;
         s_wdata <= d;
         s_awvalid <= 1'b1;
         s_wvalid <= 1'b1;
         s_bready <= 1'b1;
      end else begin
         s_araddr <= a;
         s_arvalid <= 1'b1;
         s_rready <= 1'b1;
      end
      n = 0;
      done = 1'b0;
      while (!done) begin
         if (n++ > 60) give_up();
         #1;
         ta = s_awvalid && s_awready;
         tw = s_wvalid && s_wready;
         tr = s_arvalid && s_arready;
         tb = s_bready && s_bvalid;
         rr = s_rready && s_rvalid;
         rsp = wr ? s_bresp : s_rresp;
         dat = s_rdata;
         @(posedge core_clk);
         if (ta) s_awvalid <= 1'b0;
         if (tw) s_wvalid <= 1'b0;
         if (tr) s_arvalid <= 1'b0;
         if (tb) s_bready <= 1'b0;
         if (rr) s_rready <= 1'b0;
         done = tb || rr;
      end
      chk("response", {30'h0, er}, {30'h0, rsp});
      if (!wr) chk("read data", d, dat);
      @(posedge core_clk);
   endtask
   // f: own, broadcast_cmd_n, mode, err, sync, bus, contig; gap of k steps plus half a step
   task automatic word(input int k, input logic [6:0] f);
      logic [15:0] e;
      {word_own_cmd, word_broadcast_cmd_n_cmd, word_mode_cmd, word_err} <= f[6:3];
      {word_cmd_sync, bus_select, contiguous_flag} <= f[2:0];
      word_end <= 1'b1;
      @(posedge core_clk);
      word_end <= 1'b0;
      repeat (50 * k + 24) @(posedge core_clk);
      word_start <= 1'b1;
      @(posedge core_clk);
      word_start <= 1'b0;
      word_done <= 1'b1;
      @(posedge core_clk);
      word_done <= 1'b0;
      repeat (2) @(posedge core_clk);
      e = {f[0] ? 8'h00 : (k > 255 ? 8'hff : 8'(k)), 1'b1, !f[6], !f[5], f[3], f[2:0], !f[4]};
      axi(1'b0, `MSQ_OFF_TAG, {16'h0, e}, `MSQ_RESP_OKAY);
   endtask
   task automatic pulse(input int k);
      @(posedge core_clk);
      if (k < 16) msg_ev[k] <= 1'b1;
      else nm_ev[k - 16] <= 1'b1;
      @(posedge core_clk);
      msg_ev <= 16'h0;
      nm_ev <= 4'h0;
   endtask
   task automatic entry(input logic [15:0] ew, input logic [15:0] pw);
      int n;
      for (n = 0; msq_ram_model_i.wr_cnt < nw + 2; n++) begin
         if (n > 200) give_up();
         @(posedge core_clk);
         #1;
      end
      nw += 2;
      chk("event word", {16'h0, ew}, {16'h0, msq_ram_model_i.mem[qa[9:0]]});
      chk("param word", {16'h0, pw}, {16'h0, msq_ram_model_i.mem[qa[9:0] + 10'h1]});
      qa += 16'h2;
      @(posedge core_clk);
   endtask
   task automatic none;
      repeat (30) @(posedge core_clk);
      #1;
      chk("write count", nw, msq_ram_model_i.wr_cnt);
      @(posedge core_clk);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge core_clk);
      resetn <= 1'b1;
      @(posedge core_clk);
      axi(1'b0, `MSQ_OFF_CTRL, 32'h0, `MSQ_RESP_OKAY);
      axi(1'b0, `MSQ_OFF_QPTR, 32'h0, `MSQ_RESP_OKAY);
      axi(1'b0, 8'h18, 32'h0, `MSQ_RESP_SLVERR);
      axi(1'b1, 8'h18, 32'h1, `MSQ_RESP_SLVERR);
      word(3, 7'b1000111);
      word(2, 7'b0111110);
      word(260, 7'b0000000);
      word(5, 7'b1111110);
      pulse(0);
      none();
      axi(1'b1, `MSQ_OFF_MODETBL, 32'hffff, `MSQ_RESP_OKAY);
      axi(1'b1, `MSQ_OFF_QBASE, 32'h0200, `MSQ_RESP_OKAY);
      axi(1'b1, `MSQ_OFF_CTRL, 32'h9, `MSQ_RESP_OKAY);
      transmit_done_irq_en <= 1'b1;
      qa = 16'h0200;
      for (int k = 0; k < 15; k++) begin
         slow <= (k > 7);
         pulse(k);
         entry(16'h1 | (16'h2 << k), rt_bsw_ptr);
      end
      for (int k = 0; k < 4; k++) begin
         pulse(16 + k);
         entry(16'h2 << k, k == 0 ? ram_parity_addr : 16'h0000);
      end
      slow <= 1'b0;
      axi(1'b0, `MSQ_OFF_QPTR, 32'h0226, `MSQ_RESP_OKAY);
      axi(1'b0, `MSQ_OFF_STAT, 32'h13, `MSQ_RESP_OKAY);
      axi(1'b1, `MSQ_OFF_MODETBL, 32'hfffe, `MSQ_RESP_OKAY);
      pulse(2);
      none();
      transmit_done_irq_en <= 1'b0;
      pulse(1);
      none();
      axi(1'b1, `MSQ_OFF_CTRL, 32'h6, `MSQ_RESP_OKAY);
      pulse(15);
      none();
      axi(1'b1, `MSQ_OFF_CTRL, 32'h2, `MSQ_RESP_OKAY);
      pulse(15);
      entry(16'h4001, mt_bsw_ptr);
      report_and_stop();
   end
endmodule
